// file: modbus_request_route_remap.sv
// request router: table lookup, function-code remap, offsets, client routing
// Function
// - 253-entry table by destination index holds route, mode, offsets
// - first route drop selects the outbound port by drop number
// - non-priority legacy mode emits non-priority legacy messages
// - pass-through mode forwards code and addresses unchanged
// - priority legacy mode emits priority legacy messages
// - input remap mode turns code 04 into 03, no offset
// - dual remap turns 04 into 03 and 02 into 01, no offset
// - remap-offset mode adds space offsets to 02 and 04 and remaps
// - offset modes add coil/holding offsets to coil and register codes
// - code 23 gets holding offset on read and write starts
// - pass-offset mode offsets 02 and 04 without changing codes
// - empty route serves request from internal registers
// - unmatched first drop serves request internally
// - first drop equal to Ethernet drop loops back out Ethernet
// - index 254 reserved for special codes 101 and 102
// - next drop after Ethernet indexes client table for target IP
// - further drop is destination index, else entry downstream drop
// - client IP 0.0.0.0 selects legacy 802.3 client framing
// - auto-fill sets each client IP from own address, octet four index
module modbus_request_route_remap #(
  parameter int unsigned ENTRIES = route_remap_pkg::ENTRY_COUNT,
  parameter int unsigned CLIENTS = route_remap_pkg::CLIENT_COUNT,
  parameter int unsigned NPORTS = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // own port drop numbers and address
  input wire logic [7:0] eth_drop_i,
  input wire logic [NPORTS-1:0][7:0] port_drop_i,
  input wire logic [31:0] primary_ethernet_port_ip_i,
  // routing table write
  input wire logic tbl_we_i,
  input wire logic [7:0] tbl_idx_i,
  input wire route_remap_pkg::entry_t tbl_data_i,
  // client table write and auto-fill
  input wire logic cli_we_i,
  input wire logic [7:0] cli_idx_i,
  input wire logic [31:0] cli_ip_i,
  input wire logic autofill_i,
  output logic autofill_busy_o,
  // incoming request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire route_remap_pkg::req_t req_i,
  // forwarded request
  output logic fwd_valid_o,
  input wire logic fwd_ready_i,
  output route_remap_pkg::fwd_t fwd_o
);
  localparam int unsigned FWD_W = $bits(route_remap_pkg::fwd_t);

  route_remap_pkg::entry_t table_mem [ENTRIES];
  logic [31:0] client_ip [CLIENTS];

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOOK = 3'b010,
    ST_PUSH = 3'b100
  } state_t;
  state_t state_ff;

  route_remap_pkg::req_t req_ff;
  route_remap_pkg::entry_t ent_ff;
  route_remap_pkg::fwd_t res_ff;
  logic [7:0] fill_ff;
  logic fill_busy_ff;
  logic buf_ready;
  logic buf_valid;
  route_remap_pkg::fwd_t buf_data;
  logic req_ready_ff;
  logic fwd_valid_ff;
  route_remap_pkg::fwd_t fwd_ff;

  // signed offset wraps modulo 65536
  function automatic logic [15:0] add_off(input logic [15:0] a,
                                          input logic [15:0] off);
    add_off = a + off;
  endfunction

  function automatic logic port_hit(input logic [7:0] d,
                                    input logic [NPORTS-1:0][7:0] p);
    port_hit = 1'b0;
    for (int i = 0; i < NPORTS; i++) begin
      if (p[i] == d) begin
        port_hit = 1'b1;
      end
    end
  endfunction

  // table writes; index 253 and above is never stored
  always_ff @(posedge clk_i) begin
    if (tbl_we_i && (32'(tbl_idx_i) < ENTRIES)) begin
      table_mem[tbl_idx_i] <= tbl_data_i;
    end
  end

  // client table: auto-fill walks one entry per clock
  always_ff @(posedge clk_i) begin
    if (fill_busy_ff) begin
      client_ip[fill_ff] <= {primary_ethernet_port_ip_i[31:8], fill_ff};
    end else if (cli_we_i && (32'(cli_idx_i) < CLIENTS)) begin
      client_ip[cli_idx_i] <= cli_ip_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fill_busy_ff <= 1'b0;
      fill_ff <= 8'h00;
    end else if (fill_busy_ff) begin
      fill_ff <= fill_ff + 8'h01;
      if (32'(fill_ff) == CLIENTS - 1) begin
        fill_busy_ff <= 1'b0;
      end
    end else if (autofill_i) begin
      fill_busy_ff <= 1'b1;
      fill_ff <= 8'h00;
    end
  end

  // translation of one request against its entry
  function automatic route_remap_pkg::fwd_t translate(
      input route_remap_pkg::req_t r,
      input route_remap_pkg::entry_t e,
      input logic [7:0] eth_drop,
      input logic [NPORTS-1:0][7:0] ports,
      input logic [31:0] ip_of_next);
    route_remap_pkg::fwd_t f;
    logic offs;
    f = '0;
    f.fc = r.fc;
    f.addr = r.addr;
    f.addr2 = r.addr2;
    f.fmt = route_remap_pkg::FMT_MODBUS;
    f.dst_index = r.index;
    offs = (e.mode == route_remap_pkg::MODE_REMAP_OFFSET) ||
           (e.mode == route_remap_pkg::MODE_PASS_OFFSET);
    case (e.mode)
      route_remap_pkg::MODE_LEGACY_NORMAL: begin
        f.fmt = route_remap_pkg::FMT_LEGACY_NORMAL;
      end
      route_remap_pkg::MODE_LEGACY_PRIO: begin
        f.fmt = route_remap_pkg::FMT_LEGACY_PRIO;
      end
      route_remap_pkg::MODE_REMAP_INPUT: begin
        if (r.fc == route_remap_pkg::FC_RD_INPUT) begin
          f.fc = route_remap_pkg::FC_RD_HOLD;
        end
      end
      route_remap_pkg::MODE_REMAP_DUAL,
      route_remap_pkg::MODE_REMAP_OFFSET: begin
        if (r.fc == route_remap_pkg::FC_RD_INPUT) begin
          f.fc = route_remap_pkg::FC_RD_HOLD;
        end else if (r.fc == route_remap_pkg::FC_RD_DISC) begin
          f.fc = route_remap_pkg::FC_RD_COILS;
        end
      end
      default: begin
        f.fc = r.fc;
      end
    endcase
    if (offs) begin
      case (r.fc)
        route_remap_pkg::FC_RD_COILS,
        route_remap_pkg::FC_WR_COIL,
        route_remap_pkg::FC_WR_COILS: begin
          f.addr = add_off(r.addr, e.off_coil);
        end
        route_remap_pkg::FC_RD_DISC: begin
          f.addr = add_off(r.addr, e.off_disc);
        end
        route_remap_pkg::FC_RD_INPUT: begin
          f.addr = add_off(r.addr, e.off_input);
        end
        route_remap_pkg::FC_RD_HOLD,
        route_remap_pkg::FC_WR_REG,
        route_remap_pkg::FC_WR_REGS,
        route_remap_pkg::FC_MASK_WR: begin
          f.addr = add_off(r.addr, e.off_hold);
        end
        route_remap_pkg::FC_RDWR_REGS: begin
          f.addr = add_off(r.addr, e.off_hold);
          f.addr2 = add_off(r.addr2, e.off_hold);
        end
        default: begin
          f.addr = r.addr;
        end
      endcase
    end
    // routing
    f.rest = e.route;
    f.rest_len = 4'h0;
    f.port_drop = e.route[0];
    if (e.route_len == 4'h0) begin
      f.dest = route_remap_pkg::DEST_INTERNAL;
    end else if (e.route[0] == eth_drop) begin
      f.ip = ip_of_next;
      f.dest = (ip_of_next == route_remap_pkg::IP_LEGACY) ?
               route_remap_pkg::DEST_ETH_LEGACY :
               route_remap_pkg::DEST_ETH_TCP;
      if (e.route_len > 4'h2) begin
        f.dst_index = e.route[2];
        f.rest_len = e.route_len - 4'h3;
        f.rest = e.route >> (3 * route_remap_pkg::DROP_W);
      end else begin
        f.dst_index = e.downstream;
      end
    end else if (port_hit(e.route[0], ports)) begin
      f.dest = route_remap_pkg::DEST_PORT;
      f.rest_len = e.route_len - 4'h1;
      f.rest = e.route >> route_remap_pkg::DROP_W;
    end else begin
      f.dest = route_remap_pkg::DEST_INTERNAL;
    end
    return f;
  endfunction

  // control sequence
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= ST_IDLE;
      req_ff <= '0;
      ent_ff <= '0;
      res_ff <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (req_valid_i && req_ready_o) begin
            req_ff <= req_i;
            state_ff <= ST_LOOK;
          end
        end
        ST_LOOK: begin
          state_ff <= ST_PUSH;
        end
        ST_PUSH: begin
          if (buf_ready) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
      if (state_ff == ST_IDLE && req_valid_i && req_ready_o) begin
        if (32'(req_i.index) < ENTRIES) begin
          ent_ff <= table_mem[req_i.index];
        end else begin
          ent_ff <= '0;
        end
      end
      if (state_ff == ST_LOOK) begin
        if (req_ff.index == route_remap_pkg::SPECIAL_INDEX) begin
          res_ff <= '0;
          res_ff.dest <= route_remap_pkg::DEST_SPECIAL;
          res_ff.fc <= req_ff.fc;
          res_ff.addr <= req_ff.addr;
          res_ff.addr2 <= req_ff.addr2;
          res_ff.dst_index <= req_ff.index;
        end else begin
          res_ff <= translate(req_ff, ent_ff, eth_drop_i, port_drop_i,
                              client_ip[ent_ff.route[1]]);
        end
      end
    end
  end

  // ready is a flop; auto-fill holds requests off
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_ready_ff <= 1'b0;
    end else begin
      req_ready_ff <= (state_ff == ST_IDLE) && !fill_busy_ff &&
                      !(req_valid_i && req_ready_o);
    end
  end
  assign req_ready_o = req_ready_ff;

  // buffer fills only from the push state, so a stall loses nothing
  skid_buffer #(
    .WIDTH(FWD_W),
    .DEPTH(2)
  ) u_buf (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(state_ff == ST_PUSH),
    .in_ready_o(buf_ready),
    .in_data_i(res_ff),
    .out_valid_o(buf_valid),
    .out_ready_i(fwd_ready_i && !fwd_valid_ff),
    .out_data_o(buf_data)
  );

  // registered output stage, holds until accepted
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fwd_valid_ff <= 1'b0;
      fwd_ff <= '0;
    end else if (fwd_valid_ff) begin
      if (fwd_ready_i) begin
        fwd_valid_ff <= 1'b0;
      end
    end else if (buf_valid && fwd_ready_i) begin
      fwd_valid_ff <= 1'b1;
      fwd_ff <= buf_data;
    end
  end
  assign fwd_valid_o = fwd_valid_ff;
  assign fwd_o = fwd_ff;
  assign autofill_busy_o = fill_busy_ff;
endmodule // modbus_request_route_remap

// file: route_remap_pkg.sv
// package: constants and carrier types for the request route/remap engine
package route_remap_pkg;

  localparam int unsigned ENTRY_COUNT = 253;
  localparam int unsigned IDX_W = 8;
  localparam int unsigned DROP_W = 8;
  localparam int unsigned ROUTE_LEN = 8;
  localparam int unsigned CLIENT_COUNT = 256;
  localparam logic [7:0] SPECIAL_INDEX = 8'hFE;
  localparam logic [7:0] FC_SPECIAL_A = 8'h65;
  localparam logic [7:0] FC_SPECIAL_B = 8'h66;

  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_DISC = 8'h02;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_REG = 8'h06;
  localparam logic [7:0] FC_WR_COILS = 8'h0F;
  localparam logic [7:0] FC_WR_REGS = 8'h10;
  localparam logic [7:0] FC_MASK_WR = 8'h16;
  localparam logic [7:0] FC_RDWR_REGS = 8'h17;

  localparam logic [31:0] IP_LEGACY = 32'h0000_0000;

  // rewrite modes
  typedef enum logic [2:0] {
    MODE_LEGACY_NORMAL = 3'h0,
    MODE_PASS = 3'h1,
    MODE_LEGACY_PRIO = 3'h2,
    MODE_REMAP_INPUT = 3'h3,
    MODE_REMAP_DUAL = 3'h4,
    MODE_REMAP_OFFSET = 3'h5,
    MODE_PASS_OFFSET = 3'h6
  } mode_t;

  // destination of a routed request
  typedef enum logic [2:0] {
    DEST_INTERNAL = 3'h0,
    DEST_PORT = 3'h1,
    DEST_ETH_TCP = 3'h2,
    DEST_ETH_LEGACY = 3'h3,
    DEST_SPECIAL = 3'h4
  } dest_t;

  // output message framing
  typedef enum logic [1:0] {
    FMT_MODBUS = 2'h0,
    FMT_LEGACY_NORMAL = 2'h1,
    FMT_LEGACY_PRIO = 2'h2
  } fmt_t;

  typedef struct packed {
    logic [3:0] route_len;
    logic [ROUTE_LEN-1:0][DROP_W-1:0] route;
    mode_t mode;
    logic [15:0] off_coil;
    logic [15:0] off_disc;
    logic [15:0] off_input;
    logic [15:0] off_hold;
    logic [DROP_W-1:0] downstream;
  } entry_t;

  typedef struct packed {
    logic [IDX_W-1:0] index;
    logic [7:0] fc;
    logic [15:0] addr;
    logic [15:0] addr2;
  } req_t;

  typedef struct packed {
    dest_t dest;
    fmt_t fmt;
    logic [DROP_W-1:0] port_drop;
    logic [31:0] ip;
    logic [IDX_W-1:0] dst_index;
    logic [3:0] rest_len;
    logic [ROUTE_LEN-1:0][DROP_W-1:0] rest;
    logic [7:0] fc;
    logic [15:0] addr;
    logic [15:0] addr2;
  } fwd_t;

endpackage

// file: skid_buffer.sv
// two-entry valid/ready buffer on the output path
module skid_buffer #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ff;
  logic [PW-1:0] rd_ff;
  logic [PW:0] cnt_ff;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_ff != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o = mem_ff[rd_ff];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
    inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= inc(wr_ff);
      end
      if (pop) begin
        rd_ff <= inc(rd_ff);
      end
      cnt_ff <= cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // skid_buffer

// file: route_remap_sva.sv
// checker: port-level properties of the request router
module route_remap_sva #(
  parameter int unsigned ENTRIES = 253
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // table write and auto-fill
  input wire logic tbl_we_i,
  input wire logic [7:0] tbl_idx_i,
  input wire route_remap_pkg::entry_t tbl_data_i,
  input wire logic autofill_busy_o,
  // handshakes
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire route_remap_pkg::req_t req_i,
  input wire logic fwd_valid_o,
  input wire logic fwd_ready_i,
  input wire route_remap_pkg::fwd_t fwd_o
);
  // entry captured at take time, so later table writes cannot confuse
  route_remap_pkg::entry_t shadow [256];
  route_remap_pkg::req_t q_r [4];
  route_remap_pkg::entry_t q_e [4];
  route_remap_pkg::req_t hr;
  route_remap_pkg::entry_t he;
  logic [1:0] wp_ff;
  logic [1:0] rp_ff;
  logic [8:0] busy_cnt_ff;
  assign hr = q_r[rp_ff];
  assign he = q_e[rp_ff];
  always_ff @(posedge clk_i) begin
    if (tbl_we_i && tbl_idx_i < ENTRIES) begin
      shadow[tbl_idx_i] <= tbl_data_i;
    end
    if (req_valid_i && req_ready_o) begin
      q_r[wp_ff] <= req_i;
      q_e[wp_ff] <= shadow[req_i.index];
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_ff <= 2'h0;
      rp_ff <= 2'h0;
      busy_cnt_ff <= 9'h000;
    end else begin
      wp_ff <= wp_ff + 2'(req_valid_i && req_ready_o);
      rp_ff <= rp_ff + 2'(fwd_valid_o && fwd_ready_i);
      busy_cnt_ff <= autofill_busy_o ? busy_cnt_ff + 9'h001 : 9'h000;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence took_s;
    req_valid_i && req_ready_o;
  endsequence
  sequence out_s;
    fwd_valid_o && hr.index != route_remap_pkg::SPECIAL_INDEX;
  endsequence
  answer_bound_a: assert property (
    took_s |-> ##[1:60] fwd_valid_o) else $error("no output after take");
  legacy_fmt_a: assert property (
    out_s ##0 he.mode == 3'h0 |-> fwd_o.fmt == 2'h1)
    else $error("legacy framing wrong");
  pass_same_a: assert property (
    out_s ##0 he.mode == 3'h1 |-> fwd_o.fc == hr.fc && fwd_o.addr == hr.addr)
    else $error("pass-through altered request");
  input_remap_a: assert property (
    out_s ##0 (he.mode == 3'h3 && hr.fc == 8'h04)
    |-> fwd_o.fc == 8'h03 && fwd_o.addr == hr.addr) else $error("remap wrong");
  hold_offset_a: assert property (
    out_s ##0 (he.mode == 3'h5 && hr.fc == 8'h06)
    |-> fwd_o.addr == hr.addr + he.off_hold) else $error("offset wrong");
  empty_route_a: assert property (
    out_s ##0 he.route_len == 4'h0 |-> fwd_o.dest == 3'h0)
    else $error("empty route not internal");
  special_index_a: assert property (
    fwd_valid_o && hr.index == route_remap_pkg::SPECIAL_INDEX
    |-> fwd_o.dest == 3'h4 && fwd_o.fc == hr.fc) else $error("special wrong");
  fill_length_a: assert property (
    $fell(autofill_busy_o) |-> busy_cnt_ff == 9'h100)
    else $error("auto-fill length wrong");
endmodule // route_remap_sva

bind modbus_request_route_remap route_remap_sva #(.ENTRIES(ENTRIES))
  route_remap_sva_i (.clk_i(clk_i), .nrst_i(nrst_i), .tbl_we_i(tbl_we_i),
  .tbl_idx_i(tbl_idx_i), .tbl_data_i(tbl_data_i),
  .autofill_busy_o(autofill_busy_o), .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o), .req_i(req_i), .fwd_valid_o(fwd_valid_o),
  .fwd_ready_i(fwd_ready_i), .fwd_o(fwd_o));

// file: fwd_sink.sv
// partner: downstream receiver that stalls on command and records words
module fwd_sink (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // stall command and forwarded request
  input wire logic stall_i,
  input wire logic fwd_valid_i,
  input wire route_remap_pkg::fwd_t fwd_i,
  output logic fwd_ready_o,
  // accepted word, one-cycle pulse
  output logic got_o,
  output route_remap_pkg::fwd_t got_fwd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ready moves on the falling edge, clear of the sampling edge
  always_ff @(negedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fwd_ready_o <= 1'b0;
    end else begin
      fwd_ready_o <= !stall_i;
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      got_o <= 1'b0;
      got_fwd_o <= '0;
    end else begin
      got_o <= fwd_valid_i && fwd_ready_o;
      got_fwd_o <= fwd_i;
    end
  end
endmodule // fwd_sink

// file: modbus_request_route_remap_tb.sv
// testbench: table rows and hand tests of the request router
module modbus_request_route_remap_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0] m;
    logic [3:0] n;
    logic [23:0] r;
    logic [7:0] fc;
    logic [15:0] a;
    logic [2:0] d;
    logic [1:0] f;
    logic [7:0] efc;
    logic [15:0] ea;
  } row_t;
  // mode, length, route, code, addr -> dest, framing, code, addr
  localparam row_t ROWS [11] = '{
    '{3'h1, 4'h2, 24'h150900, 8'h04, 16'h0100, 3'h1, 2'h0, 8'h04, 16'h0100},
    '{3'h0, 4'h2, 24'h150900, 8'h03, 16'h0100, 3'h1, 2'h1, 8'h03, 16'h0100},
    '{3'h2, 4'h2, 24'h150900, 8'h03, 16'h0100, 3'h1, 2'h2, 8'h03, 16'h0100},
    '{3'h3, 4'h2, 24'h150900, 8'h04, 16'h0100, 3'h1, 2'h0, 8'h03, 16'h0100},
    '{3'h4, 4'h2, 24'h150900, 8'h02, 16'h0100, 3'h1, 2'h0, 8'h01, 16'h0100},
    '{3'h5, 4'h2, 24'h150900, 8'h02, 16'h0100, 3'h1, 2'h0, 8'h01, 16'h0102},
    '{3'h5, 4'h2, 24'h150900, 8'h04, 16'h0100, 3'h1, 2'h0, 8'h03, 16'h0103},
    '{3'h5, 4'h2, 24'h150900, 8'h06, 16'h0000, 3'h1, 2'h0, 8'h06, 16'hFFFF},
    '{3'h6, 4'h2, 24'h150900, 8'h04, 16'h0100, 3'h1, 2'h0, 8'h04, 16'h0103},
    '{3'h1, 4'h0, 24'h000000, 8'h03, 16'h0100, 3'h0, 2'h0, 8'h03, 16'h0100},
    '{3'h1, 4'h2, 24'h330900, 8'h03, 16'h0100, 3'h0, 2'h0, 8'h03, 16'h0100}};
  localparam logic [31:0] OWN_IP = 32'hC0A8_0A07;
  localparam logic [31:0] CLI_IP = 32'h0A00_0114;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic tbl_we = 1'b0;
  logic cli_we = 1'b0;
  logic autofill = 1'b0;
  logic req_valid = 1'b0;
  logic stall = 1'b0;
  logic [7:0] tbl_idx = 8'h00;
  logic [7:0] cli_idx = 8'h00;
  logic [31:0] cli_ip = 32'h0000_0000;
  route_remap_pkg::entry_t tbl_data = '0;
  route_remap_pkg::req_t req = '0;
  route_remap_pkg::fwd_t fwd;
  route_remap_pkg::fwd_t seen;
  logic fwd_valid, fwd_ready, req_ready, busy, got;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  modbus_request_route_remap modbus_request_route_remap_i (
    .clk_i(clk), .nrst_i(nrst), .eth_drop_i(8'h5A),
    .port_drop_i({8'h03, 8'h02, 8'h15}), .primary_ethernet_port_ip_i(OWN_IP),
    .tbl_we_i(tbl_we), .tbl_idx_i(tbl_idx), .tbl_data_i(tbl_data),
    .cli_we_i(cli_we), .cli_idx_i(cli_idx), .cli_ip_i(cli_ip),
    .autofill_i(autofill), .autofill_busy_o(busy),
    .req_valid_i(req_valid), .req_ready_o(req_ready), .req_i(req),
    .fwd_valid_o(fwd_valid), .fwd_ready_i(fwd_ready), .fwd_o(fwd));
  fwd_sink fwd_sink_i (.clk_i(clk), .nrst_i(nrst), .stall_i(stall),
    .fwd_valid_i(fwd_valid), .fwd_i(fwd), .fwd_ready_o(fwd_ready),
    .got_o(got), .got_fwd_o(seen));
  task automatic check(input logic [31:0] val, input logic [31:0] exp);
    total_checks++;
    if (val !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, val, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic wr_tbl(input logic [7:0] i, input logic [2:0] m,
      input logic [3:0] n, input logic [23:0] r);
    @(negedge clk);
    tbl_idx = i;
    tbl_data = '0;
    tbl_data.mode = route_remap_pkg::mode_t'(m);
    tbl_data.route_len = n;
    tbl_data.route[0] = r[23:16];
    tbl_data.route[1] = r[15:8];
    tbl_data.route[2] = r[7:0];
    tbl_data.off_coil = 16'h0001;
    tbl_data.off_disc = 16'h0002;
    tbl_data.off_input = 16'h0003;
    tbl_data.off_hold = 16'hFFFF;
    tbl_data.downstream = 8'h07;
    tbl_we = 1'b1;
    @(negedge clk);
    tbl_we = 1'b0;
  endtask
  task automatic wr_cli(input logic [7:0] i, input logic [31:0] ip);
    @(negedge clk);
    cli_idx = i;
    cli_ip = ip;
    cli_we = 1'b1;
    @(negedge clk);
    cli_we = 1'b0;
  endtask
  task automatic put_req(input logic [7:0] i, input logic [7:0] fc,
      input logic [15:0] a, input logic [15:0] a2);
    int n;
    n = 0;
    @(negedge clk);
    req = {i, fc, a, a2};
    req_valid = 1'b1;
    // ready is a flop: its level at the falling edge is what the
    // next rising edge samples
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    check(n < 200, 1'b1);
  endtask
  task automatic get_fwd();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (got !== 1'b1 && n < 200);
    check(got, 1'b1);
  endtask
  task automatic send(input logic [7:0] i, input logic [7:0] fc,
      input logic [15:0] a, input logic [15:0] a2);
    put_req(i, fc, a, a2);
    get_fwd();
  endtask
  task automatic rst_chk();
    check({req_ready, fwd_valid, busy}, 3'h0);
  endtask
  initial begin
    int n;
    repeat (4) @(negedge clk);
    rst_chk();
    nrst = 1'b1;
    wr_cli(8'h14, CLI_IP);
    wr_cli(8'h1E, 32'h0000_0000);
    for (int k = 0; k < 11; k++) begin
      wr_tbl(8'(k + 1), ROWS[k].m, ROWS[k].n, ROWS[k].r);
      send(8'(k + 1), ROWS[k].fc, ROWS[k].a, 16'h0000);
      check(seen.dest, ROWS[k].d);
      check(seen.fmt, ROWS[k].f);
      check(seen.fc, ROWS[k].efc);
      check(seen.addr, ROWS[k].ea);
      if (ROWS[k].d == 3'h1) begin
        check(seen.port_drop, ROWS[k].r[23:16]);
        check(seen.rest[0], ROWS[k].r[15:8]);
      end
    end
    $display("table rows done");
    wr_tbl(8'h28, 3'h1, 4'h3, 24'h5A142A);
    send(8'h28, 8'h03, 16'h0100, 16'h0000);
    check(seen.dest, 3'h2);
    check(seen.ip, CLI_IP);
    check(seen.dst_index, 8'h2A);
    wr_tbl(8'h29, 3'h1, 4'h2, 24'h5A1400);
    send(8'h29, 8'h03, 16'h0100, 16'h0000);
    check(seen.dst_index, 8'h07);
    wr_tbl(8'h2A, 3'h1, 4'h2, 24'h5A1E00);
    send(8'h2A, 8'h03, 16'h0100, 16'h0000);
    check(seen.dest, 3'h3);
    for (int k = 0; k < 2; k++) begin
      send(route_remap_pkg::SPECIAL_INDEX, 8'h65 + 8'(k), 16'h1234, 16'h0);
      check(seen.dest, 3'h4);
      check(seen.fc, 8'h65 + 8'(k));
    end
    wr_tbl(8'h2C, 3'h5, 4'h2, 24'h150900);
    send(8'h2C, 8'h17, 16'h0010, 16'h0020);
    check({seen.addr, seen.addr2}, 32'h000F_001F);
    // last stored index works, the one past the table is never stored
    wr_tbl(8'hFC, 3'h1, 4'h2, 24'h150900);
    send(8'hFC, 8'h03, 16'h0100, 16'h0000);
    check(seen.dest, 3'h1);
    wr_tbl(8'hFD, 3'h1, 4'h2, 24'h150900);
    send(8'hFD, 8'h03, 16'h0100, 16'h0000);
    check(seen.dest, 3'h0);
    $display("routes and special codes done");
    @(negedge clk);
    autofill = 1'b1;
    cli_idx = 8'h05;
    @(negedge clk);
    autofill = 1'b0;
    n = 0;
    while (busy === 1'b1 && n < 400) begin
      cli_we = (n == 8);
      if (n == 8) check(req_ready, 1'b0);
      @(negedge clk);
      n++;
    end
    cli_we = 1'b0;
    check(n, 256);
    wr_tbl(8'h2B, 3'h1, 4'h2, 24'h5A0500);
    send(8'h2B, 8'h03, 16'h0100, 16'h0000);
    check(seen.ip, {OWN_IP[31:8], 8'h05});
    $display("auto-fill done");
    stall <= 1'b1;
    put_req(8'h01, 8'h04, 16'h0100, 16'h0000);
    put_req(8'h01, 8'h04, 16'h0200, 16'h0000);
    // third word finds the buffer full and parks in the push state
    put_req(8'h01, 8'h04, 16'h0300, 16'h0000);
    repeat (8) @(negedge clk);
    check(req_ready, 1'b0);
    stall <= 1'b0;
    get_fwd();
    check(seen.addr, 16'h0100);
    get_fwd();
    check(seen.addr, 16'h0200);
    get_fwd();
    check(seen.addr, 16'h0300);
    $display("stall done");
    nrst = 1'b0;
    @(negedge clk);
    rst_chk();
    nrst = 1'b1;
    send(8'h01, 8'h04, 16'h0400, 16'h0000);
    check(seen.addr, 16'h0400);
    $display("reset done");
    end_of_test();
  end
endmodule // modbus_request_route_remap_tb
